// ==== radio_extended_mode_control.sv ====
// Extended mode register bank with serial access and frame decisions
`timescale 1ns/100ps

module radio_extended_mode_control #(
   parameter int ACK_CNT_WIDTH = 4
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic spi_sclk,
   input wire logic spi_sel_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   input wire logic [4:0] radio_state,
   input wire logic high_rate_group,
   input wire logic procedure_start,
   input wire logic result_valid,
   input wire logic [2:0] result_code,
   input wire logic tx_no_ack,
   input wire logic symbol_tick,
   input wire logic frame_done,
   input wire logic phr_valid,
   input wire logic frame_reserved_type,
   input wire logic fcs_ok,
   input wire logic filter_pass,
   input wire logic ack_requested,
   input wire logic ack_suppress,
   output logic command_strobe,
   output logic [4:0] command_code,
   output logic auto_fcs_enable,
   output logic reserved_type_filter,
   output logic reserved_type_upload,
   output logic promiscuous_enable,
   output logic [3:0] ack_delay_symbols,
   output logic [3:0] frame_retry_limit,
   output logic [2:0] channel_access_retry_limit,
   output logic csma_bypass,
   output logic slotted_operation,
   output logic retransmit,
   output logic frame_end_irq,
   output logic address_match_irq,
   output logic frame_discard,
   output logic ack_launch
);

   // ==========================================================
   // Elaboration check
   if (ACK_CNT_WIDTH < 4) begin : g_width_check
      $error("ACK_CNT_WIDTH must hold a count of twelve");
   end

   typedef enum logic [1:0] {spi_idle, spi_cmd, spi_data, spi_done} spi_state_t;

   // ==========================================================
   // Serial access and register state
   spi_state_t spi_state, next_spi_state;
   logic sclk_prev, next_sclk_prev;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [7:0] rx_shift, next_rx_shift;
   logic [7:0] tx_shift, next_tx_shift;
   logic [7:0] access_byte, next_access_byte;
   logic next_miso, next_miso_oe;
   logic [7:0] mpc, next_mpc;
   logic [7:0] xctrl1, next_xctrl1;
   logic [7:0] xctrl0, next_xctrl0;
   logic [4:0] state_cmd, next_state_cmd;
   logic next_command_strobe;
   logic [4:0] next_command_code;
   logic [7:0] read_word;
   logic [2:0] result;

   // Address is complete with the live last bit, so the word is ready for byte two
   always_comb begin
      case ({rx_shift[4:0], spi_mosi})
         radio_xmode_pkg::ADDR_RADIO_STATE: read_word = {3'h0, radio_state};
         radio_xmode_pkg::ADDR_STATE_CMD: read_word = {result, state_cmd};
         radio_xmode_pkg::ADDR_MPC: read_word = mpc;
         radio_xmode_pkg::ADDR_XCTRL1: read_word = xctrl1;
         radio_xmode_pkg::ADDR_XCTRL0: read_word = xctrl0;
         default: read_word = 8'h00;
      endcase
   end

   always_comb begin
      next_spi_state = spi_state;
      next_sclk_prev = spi_sclk;
      next_bit_cnt = bit_cnt;
      next_rx_shift = rx_shift;
      next_tx_shift = tx_shift;
      next_access_byte = access_byte;
      next_miso = spi_miso;
      next_miso_oe = spi_miso_oe;
      next_mpc = mpc;
      next_xctrl1 = xctrl1;
      next_xctrl0 = xctrl0;
      next_state_cmd = state_cmd;
      next_command_strobe = 1'b0;
      next_command_code = command_code;
      if (spi_sel_n) begin
         next_spi_state = spi_idle;
         next_bit_cnt = 3'h0;
         next_miso = 1'b0;
         next_miso_oe = 1'b0;
      end else begin
         case (spi_state)
            spi_idle: begin
               next_spi_state = spi_cmd;
               next_bit_cnt = 3'h0;
               next_miso_oe = 1'b1;
            end
            spi_cmd: begin
               if (spi_sclk && !sclk_prev) begin
                  next_rx_shift = {rx_shift[6:0], spi_mosi};
                  next_bit_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == radio_xmode_pkg::SPI_LAST_BIT) begin
                     next_access_byte = {rx_shift[6:0], spi_mosi};
                     next_tx_shift = read_word;
                     next_spi_state = spi_data;
                  end
               end
            end
            spi_data: begin
               // Data changes on the falling edge for a mode 0 master
               if (!spi_sclk && sclk_prev) begin
                  next_miso = tx_shift[7];
                  next_tx_shift = {tx_shift[6:0], 1'b0};
               end
               if (spi_sclk && !sclk_prev) begin
                  next_rx_shift = {rx_shift[6:0], spi_mosi};
                  next_bit_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == radio_xmode_pkg::SPI_LAST_BIT) begin
                     next_spi_state = spi_done;
                     if (access_byte[7:6] == radio_xmode_pkg::SPI_WRITE_PREFIX) begin
                        case (access_byte[5:0])
                           radio_xmode_pkg::ADDR_STATE_CMD: begin
                              next_state_cmd = rx_shift[3:0] == 4'h0 &&
                                 !spi_mosi ? 5'h00 : {rx_shift[3:0], spi_mosi};
                              next_command_strobe = 1'b1;
                              next_command_code = radio_xmode_pkg::decode_command(
                                 {rx_shift[3:0], spi_mosi});
                           end
                           radio_xmode_pkg::ADDR_MPC:
                              next_mpc = {rx_shift[6:0], spi_mosi} &
                                 radio_xmode_pkg::MASK_MPC;
                           radio_xmode_pkg::ADDR_XCTRL1:
                              next_xctrl1 = {rx_shift[6:0], spi_mosi} &
                                 radio_xmode_pkg::MASK_XCTRL1;
                           radio_xmode_pkg::ADDR_XCTRL0:
                              next_xctrl0 = {rx_shift[6:0], spi_mosi} &
                                 radio_xmode_pkg::MASK_XCTRL0;
                           default: ;
                        endcase
                     end
                  end
               end
            end
            spi_done: begin
               // Further bytes in the same selection are ignored
               if (!spi_sclk && sclk_prev) begin
                  next_miso = 1'b0;
               end
            end
            default: next_spi_state = spi_idle;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         spi_state <= spi_idle;
         sclk_prev <= 1'b0;
         bit_cnt <= 3'h0;
         rx_shift <= 8'h00;
         tx_shift <= 8'h00;
         access_byte <= 8'h00;
         spi_miso <= 1'b0;
         spi_miso_oe <= 1'b0;
         mpc <= radio_xmode_pkg::RST_MPC;
         xctrl1 <= radio_xmode_pkg::RST_XCTRL1;
         xctrl0 <= radio_xmode_pkg::RST_XCTRL0;
         state_cmd <= radio_xmode_pkg::RST_STATE_CMD;
         command_strobe <= 1'b0;
         command_code <= radio_xmode_pkg::CMD_NO_OPERATION;
      end else begin
         spi_state <= next_spi_state;
         sclk_prev <= next_sclk_prev;
         bit_cnt <= next_bit_cnt;
         rx_shift <= next_rx_shift;
         tx_shift <= next_tx_shift;
         access_byte <= next_access_byte;
         spi_miso <= next_miso;
         spi_miso_oe <= next_miso_oe;
         mpc <= next_mpc;
         xctrl1 <= next_xctrl1;
         xctrl0 <= next_xctrl0;
         state_cmd <= next_state_cmd;
         command_strobe <= next_command_strobe;
         command_code <= next_command_code;
      end
   end

   // ==========================================================
   // Configuration fields
   assign auto_fcs_enable = mpc[radio_xmode_pkg::MPC_AUTO_FCS];
   assign reserved_type_filter = xctrl1[radio_xmode_pkg::X1_RES_FILTER];
   assign reserved_type_upload = xctrl1[radio_xmode_pkg::X1_RES_UPLOAD];
   assign promiscuous_enable = xctrl1[radio_xmode_pkg::X1_PROMISC];
   assign frame_retry_limit = xctrl0[radio_xmode_pkg::X0_FRAME_RETRY_HI:
      radio_xmode_pkg::X0_FRAME_RETRY_LO];
   assign channel_access_retry_limit = xctrl0[radio_xmode_pkg::X0_CA_RETRY_HI:
      radio_xmode_pkg::X0_CA_RETRY_LO];
   assign slotted_operation = xctrl0[radio_xmode_pkg::X0_SLOTTED];

   // ==========================================================
   // Transaction result and retries
   logic [3:0] retry_cnt, next_retry_cnt;
   logic [2:0] next_result;
   logic next_retransmit, next_csma_bypass;
   logic [3:0] next_ack_delay;

   always_comb begin
      next_result = result;
      next_retry_cnt = retry_cnt;
      next_retransmit = 1'b0;
      // Start wins: a stale completion must not overwrite the new run
      if (procedure_start) begin
         next_result = radio_xmode_pkg::RES_INVALID;
         next_retry_cnt = 4'h0;
      end else if (result_valid) begin
         next_result = result_code;
      end else if (tx_no_ack) begin
         if (retry_cnt < frame_retry_limit) begin
            next_retransmit = 1'b1;
            next_retry_cnt = retry_cnt + 4'h1;
         end else begin
            next_result = radio_xmode_pkg::RES_NO_ACK;
         end
      end
      next_csma_bypass = channel_access_retry_limit ==
         radio_xmode_pkg::CA_RETRY_IMMEDIATE;
      if (!xctrl1[radio_xmode_pkg::X1_SHORT_ACK]) begin
         next_ack_delay = radio_xmode_pkg::ACK_DELAY_NORMAL;
      end else if (high_rate_group) begin
         next_ack_delay = radio_xmode_pkg::ACK_DELAY_SHORT_FAST;
      end else begin
         next_ack_delay = radio_xmode_pkg::ACK_DELAY_SHORT_SLOW;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         result <= radio_xmode_pkg::RST_RESULT;
         retry_cnt <= 4'h0;
         retransmit <= 1'b0;
         csma_bypass <= 1'b0;
         ack_delay_symbols <= radio_xmode_pkg::ACK_DELAY_NORMAL;
      end else begin
         result <= next_result;
         retry_cnt <= next_retry_cnt;
         retransmit <= next_retransmit;
         csma_bypass <= next_csma_bypass;
         ack_delay_symbols <= next_ack_delay;
      end
   end

   // ==========================================================
   // Receive decisions and acknowledgment timing
   logic ack_wait, next_ack_wait;
   logic [ACK_CNT_WIDTH-1:0] ack_cnt, next_ack_cnt;
   logic next_frame_end, next_ami, next_discard, next_ack_launch;

   always_comb begin
      next_frame_end = 1'b0;
      next_ami = 1'b0;
      next_discard = 1'b0;
      next_ack_launch = 1'b0;
      next_ack_wait = ack_wait;
      next_ack_cnt = ack_cnt;
      if (ack_wait && symbol_tick) begin
         if (ack_cnt <= ACK_CNT_WIDTH'(1)) begin
            next_ack_launch = 1'b1;
            next_ack_wait = 1'b0;
         end else begin
            next_ack_cnt = ack_cnt - ACK_CNT_WIDTH'(1);
         end
      end
      if (frame_done && phr_valid) begin
         if (frame_reserved_type && !reserved_type_upload) begin
            next_discard = 1'b1;
         end else if (frame_reserved_type && !reserved_type_filter) begin
            next_frame_end = fcs_ok || promiscuous_enable;
         end else begin
            // Normal frames and filtered reserved frames share this path
            next_ami = filter_pass;
            next_frame_end = (filter_pass && fcs_ok) ||
               promiscuous_enable;
            if (filter_pass && fcs_ok && ack_requested && !ack_suppress) begin
               next_ack_wait = 1'b1;
               next_ack_cnt = ACK_CNT_WIDTH'(ack_delay_symbols);
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ack_wait <= 1'b0;
         ack_cnt <= '0;
         frame_end_irq <= 1'b0;
         address_match_irq <= 1'b0;
         frame_discard <= 1'b0;
         ack_launch <= 1'b0;
      end else begin
         ack_wait <= next_ack_wait;
         ack_cnt <= next_ack_cnt;
         frame_end_irq <= next_frame_end;
         address_match_irq <= next_ami;
         frame_discard <= next_discard;
         ack_launch <= next_ack_launch;
      end
   end

endmodule

// ==== radio_xmode_pkg.sv ====
// Constants for the extended mode control and status registers
package radio_xmode_pkg;

   // ==========================================================
   // Register addresses on the serial port
   localparam logic [5:0] ADDR_RADIO_STATE = 6'h01;
   localparam logic [5:0] ADDR_STATE_CMD = 6'h02;
   localparam logic [5:0] ADDR_MPC = 6'h04;
   localparam logic [5:0] ADDR_XCTRL1 = 6'h17;
   localparam logic [5:0] ADDR_XCTRL0 = 6'h2C;

   // ==========================================================
   // Reset values and writable masks
   localparam logic [7:0] RST_MPC = 8'h20;
   localparam logic [7:0] RST_XCTRL1 = 8'h00;
   localparam logic [7:0] RST_XCTRL0 = 8'h38;
   localparam logic [7:0] MASK_MPC = 8'hFF;
   localparam logic [7:0] MASK_XCTRL1 = 8'h76;
   localparam logic [7:0] MASK_XCTRL0 = 8'hFF;
   localparam logic [4:0] RST_STATE_CMD = 5'h00;

   // ==========================================================
   // Field positions
   localparam int MPC_AUTO_FCS = 5;
   localparam int X1_RES_FILTER = 5;
   localparam int X1_RES_UPLOAD = 4;
   localparam int X1_SHORT_ACK = 2;
   localparam int X1_PROMISC = 1;
   localparam int X0_FRAME_RETRY_HI = 7;
   localparam int X0_FRAME_RETRY_LO = 4;
   localparam int X0_CA_RETRY_HI = 3;
   localparam int X0_CA_RETRY_LO = 1;
   localparam int X0_SLOTTED = 0;

   // ==========================================================
   // State commands
   localparam logic [4:0] CMD_NO_OPERATION = 5'h00;
   localparam logic [4:0] CMD_TX_LAUNCH = 5'h02;
   localparam logic [4:0] CMD_FORCED_RADIO_OFF = 5'h03;
   localparam logic [4:0] CMD_FORCED_SYNTH_ON = 5'h04;
   localparam logic [4:0] CMD_RX_ON = 5'h06;
   localparam logic [4:0] CMD_RADIO_OFF = 5'h08;
   localparam logic [4:0] CMD_SYNTH_ON = 5'h09;
   localparam logic [4:0] CMD_AUTO_ACK_RECEIVE = 5'h16;
   localparam logic [4:0] CMD_AUTO_RETRY_TRANSMIT = 5'h19;

   // ==========================================================
   // Transaction result codes
   localparam logic [2:0] RES_SUCCESS = 3'h0;
   localparam logic [2:0] RES_SUCCESS_PENDING = 3'h1;
   localparam logic [2:0] RES_SUCCESS_WAIT_ACK = 3'h2;
   localparam logic [2:0] RES_CHANNEL_FAIL = 3'h3;
   localparam logic [2:0] RES_NO_ACK = 3'h5;
   localparam logic [2:0] RES_INVALID = 3'h7;
   localparam logic [2:0] RST_RESULT = RES_SUCCESS;

   // ==========================================================
   // Acknowledgment turnaround in symbol periods and the channel access bypass code
   localparam logic [3:0] ACK_DELAY_NORMAL = 4'hC;
   localparam logic [3:0] ACK_DELAY_SHORT_SLOW = 4'h2;
   localparam logic [3:0] ACK_DELAY_SHORT_FAST = 4'h3;
   localparam logic [2:0] CA_RETRY_IMMEDIATE = 3'h7;

   // ==========================================================
   // Serial access framing
   localparam logic [1:0] SPI_READ_PREFIX = 2'h2;
   localparam logic [1:0] SPI_WRITE_PREFIX = 2'h3;
   localparam logic [2:0] SPI_LAST_BIT = 3'h7;

   // Unknown codes fall back to no operation
   function automatic logic [4:0] decode_command(input logic [4:0] code);
      case (code)
         CMD_TX_LAUNCH, CMD_FORCED_RADIO_OFF, CMD_FORCED_SYNTH_ON,
         CMD_RX_ON, CMD_RADIO_OFF, CMD_SYNTH_ON, CMD_AUTO_ACK_RECEIVE,
         CMD_AUTO_RETRY_TRANSMIT: decode_command = code;
         default: decode_command = CMD_NO_OPERATION;
      endcase
   endfunction

endpackage

// ==== radio_xmode_properties.sv ====
// Assertion checker for the extended mode register bank ports
`timescale 1ns/100ps
module radio_xmode_properties (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic command_strobe,
   input wire logic [4:0] command_code,
   input wire logic auto_fcs_enable,
   input wire logic [3:0] frame_retry_limit,
   input wire logic [2:0] channel_access_retry_limit,
   input wire logic [3:0] ack_delay_symbols,
   input wire logic high_rate_group,
   input wire logic csma_bypass,
   input wire logic frame_done,
   input wire logic phr_valid,
   input wire logic frame_reserved_type,
   input wire logic fcs_ok,
   input wire logic promiscuous_enable,
   input wire logic reserved_type_upload,
   input wire logic reserved_type_filter,
   input wire logic frame_end_irq,
   input wire logic frame_discard,
   input wire logic tx_no_ack,
   input wire logic procedure_start,
   input wire logic result_valid,
   input wire logic retransmit,
   input wire logic spi_sel_n,
   input wire logic spi_miso_oe
);
   // ==========================================================
   // Clocking
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // Properties
   property p_reset_values;
      !$past(rstn) |-> auto_fcs_enable && frame_retry_limit == 4'h3 &&
         channel_access_retry_limit == 3'h4 && ack_delay_symbols == 4'hC;
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("reset value wrong");
   property p_cmd_code;
      command_strobe |-> command_code inside {5'h00, 5'h02, 5'h03, 5'h04,
         5'h06, 5'h08, 5'h09, 5'h16, 5'h19};
   endproperty
   a_cmd_code: assert property (p_cmd_code)
      else $error("undefined command code issued");
   property p_ack_delay;
      ack_delay_symbols != 4'hC && $stable(high_rate_group) |->
         ack_delay_symbols == (high_rate_group ? 4'h3 : 4'h2);
   endproperty
   a_ack_delay: assert property (p_ack_delay)
      else $error("short ack delay wrong");
   property p_csma_bypass;
      $stable(channel_access_retry_limit) |->
         csma_bypass == (channel_access_retry_limit == 3'h7);
   endproperty
   a_csma_bypass: assert property (p_csma_bypass)
      else $error("channel access bypass wrong");
   property p_prom_end;
      frame_done && phr_valid && promiscuous_enable && !frame_reserved_type
         |=> frame_end_irq;
   endproperty
   a_prom_end: assert property (p_prom_end)
      else $error("promiscuous frame end missing");
   property p_discard;
      frame_done && phr_valid && frame_reserved_type && !reserved_type_upload
         |=> frame_discard && !frame_end_irq;
   endproperty
   a_discard: assert property (p_discard)
      else $error("reserved frame not discarded");
   property p_upload;
      frame_done && phr_valid && frame_reserved_type && reserved_type_upload
         && !reserved_type_filter && !promiscuous_enable
         |=> frame_end_irq == $past(fcs_ok);
   endproperty
   a_upload: assert property (p_upload)
      else $error("uploaded reserved frame end wrong");
   property p_retry_zero;
      tx_no_ack && !procedure_start && !result_valid &&
         frame_retry_limit == 4'h0 |=> !retransmit;
   endproperty
   a_retry_zero: assert property (p_retry_zero)
      else $error("retransmit with zero limit");
   property p_retry_cause;
      retransmit |-> $past(tx_no_ack);
   endproperty
   a_retry_cause: assert property (p_retry_cause)
      else $error("retransmit without missing ack");
   property p_miso_oe;
      spi_miso_oe == !$past(spi_sel_n);
   endproperty
   a_miso_oe: assert property (p_miso_oe)
      else $error("serial output enable wrong");
   c_cmd: cover property (command_strobe && command_code == 5'h19);
   c_retry: cover property (retransmit);
   c_discard: cover property (frame_discard);
endmodule

// ==== spi_host_model.sv ====
// Serial host model that reaches the register bank
`timescale 1ns/100ps
module spi_host_model (
   input wire logic mclk,
   input wire logic spi_miso,
   output logic spi_sclk,
   output logic spi_sel_n,
   output logic spi_mosi,
   output logic rd_done,
   output logic [7:0] rd_data
);
   // Half period in mclk cycles; three keeps miso settled before sampling
   int half = 3;
   logic [4:0] last_state = 5'h00;
   initial begin
      {spi_sclk, spi_mosi, rd_done} = 3'h0;
      spi_sel_n = 1'b1;
      rd_data = 8'h00;
   end
   // ==========================================================
   // One access per selection
   task automatic access(input logic wr, input logic [5:0] a,
         input logic [7:0] d);
      logic [15:0] f;
      f = {1'b1, wr, a, d};
      @(posedge mclk);
      spi_sel_n <= 1'b0;
      repeat (2) @(posedge mclk);
      for (int i = 15; i >= 0; i--) begin
         spi_sclk <= 1'b0;
         spi_mosi <= f[i];
         repeat (half) @(posedge mclk);
         if (i < 8) rd_data[i] = spi_miso;
         spi_sclk <= 1'b1;
         repeat (half) @(posedge mclk);
      end
      // Released line shows the inverse, never a stale copy
      spi_sel_n <= 1'b1;
      spi_sclk <= 1'b0;
      spi_mosi <= ~spi_mosi;
      rd_done <= !wr;
      @(posedge mclk);
      rd_done <= 1'b0;
      @(posedge mclk);
   endtask
   // ==========================================================
   // Command followed by a state read-back
   task automatic command(input logic [4:0] c);
      if (c == 5'h04 && last_state inside {5'h00, 5'h0F, 5'h1C, 5'h1D,
         5'h1E, 5'h1F}) return;
      access(1'b1, 6'h02, {3'h0, c});
      access(1'b0, 6'h01, 8'h00);
      last_state = rd_data[4:0];
   endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the extended mode register bank
`timescale 1ns/100ps
module testbench;
   logic mclk, rstn, spi_sclk, spi_sel_n, spi_mosi, spi_miso, spi_miso_oe;
   logic [4:0] radio_state, command_code;
   logic [2:0] result_code, channel_access_retry_limit;
   logic [3:0] ack_delay_symbols, frame_retry_limit;
   logic high_rate_group, procedure_start, result_valid, tx_no_ack;
   logic symbol_tick, frame_done, phr_valid, frame_reserved_type, fcs_ok;
   logic filter_pass, ack_requested, ack_suppress, command_strobe;
   logic auto_fcs_enable, reserved_type_filter, reserved_type_upload;
   logic promiscuous_enable, csma_bypass, slotted_operation, retransmit;
   logic frame_end_irq, address_match_irq, frame_discard, ack_launch, rd_done;
   logic [7:0] rd_data, v;
   logic [7:0] launches = 8'h00;
   logic [31:0] seed = 32'h00012A17;
   int err_total = 0;
   int checks = 0;
   logic [7:0] rd_q[$];
   logic [4:0] cmd_q[$];
   logic [7:0] fx[5] = '{8'h02, 8'h00, 8'h10, 8'h10, 8'h30};
   logic [3:0] fq[5] = '{4'h0, 4'h8, 4'hC, 4'h8, 4'hE};
   logic [2:0] fe[5] = '{3'h4, 3'h1, 3'h4, 3'h0, 3'h6};
   logic [7:0] ax[4] = '{8'h02, 8'h06, 8'h06, 8'h02};
   logic [3:0] an[4] = '{4'hC, 4'h2, 4'h3, 4'hC};
   logic ah[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
   logic as[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
   logic [2:0] rc[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
   logic [5:0] ra[3] = '{6'h04, 6'h17, 6'h2C};
   logic [7:0] rm[3] = '{8'hFF, 8'h76, 8'hFF};

   radio_extended_mode_control i_dut (.*);
   spi_host_model i_host (.*);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // ==========================================================
   // Checking and closing
   task automatic check(input string what, input logic [7:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      // Expectations that never met a result count as mismatches
      err_total += rd_q.size() + cmd_q.size();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   function logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   always @(posedge mclk) begin
      if (rd_done === 1'b1)
         check("read data", rd_data, rd_q.pop_front());
      if (command_strobe === 1'b1)
         check("command", {3'h0, command_code}, {3'h0, cmd_q.pop_front()});
      if (ack_launch === 1'b1)
         launches <= launches + 8'h01;
   end
   initial begin
      repeat (60000) @(posedge mclk);
      err_total++;
      tally_and_finish();
   end
   // ==========================================================
   // Drivers
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      i_host.access(1'b0, a, 8'h00);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      i_host.access(1'b1, a, d);
   endtask
   task automatic strobe(input logic [2:0] s);
      @(posedge mclk);
      {procedure_start, result_valid, tx_no_ack} <= s;
      @(posedge mclk);
      {procedure_start, result_valid, tx_no_ack} <= 3'h0;
      #1;
   endtask
   task automatic frame(input logic [3:0] q);
      @(posedge mclk);
      frame_done <= 1'b1;
      phr_valid <= 1'b1;
      {frame_reserved_type, fcs_ok, filter_pass, ack_requested} <= q;
      @(posedge mclk);
      frame_done <= 1'b0;
      #1;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      {procedure_start, result_valid, tx_no_ack, symbol_tick} = 4'h0;
      {frame_done, phr_valid, frame_reserved_type, fcs_ok} = 4'h0;
      {filter_pass, ack_requested, ack_suppress, high_rate_group} = 4'h0;
      result_code = 3'h0;
      radio_state = 5'h08;
      rstn = 1'b0;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      rd(6'h04, 8'h20);
      rd(6'h17, 8'h00);
      rd(6'h2C, 8'h38);
      rd(6'h02, 8'h00);
      $display("test reset values done");
      for (int c = 0; c < 32; c++) begin
         // Core states vary but stay clear of the no-clock group
         v = 8'h08 | (rnd() & 8'h11);
         radio_state <= v[4:0];
         rd_q.push_back(v);
         v = {3'h0, c[4:0]};
         cmd_q.push_back(v[4:0] inside {5'h02, 5'h03, 5'h04, 5'h06, 5'h08,
            5'h09, 5'h16, 5'h19} ? v[4:0] : 5'h00);
         i_host.command(v[4:0]);
      end
      rd(6'h02, 8'h1F);
      wr(6'h3F, 8'hA5);
      rd(6'h3F, 8'h00);
      wr(6'h01, 8'hFF);
      rd(6'h01, {3'h0, radio_state});
      $display("test commands done");
      strobe(3'h6);
      rd(6'h02, 8'hFF);
      for (int i = 0; i < 5; i++) begin
         result_code <= rc[i];
         strobe(3'h2);
         rd(6'h02, {rc[i], 5'h1F});
      end
      wr(6'h2C, 8'h28);
      strobe(3'h4);
      for (int i = 0; i < 3; i++) begin
         strobe(3'h1);
         check("retransmit", {7'h0, retransmit}, {7'h0, i < 2});
      end
      rd(6'h02, 8'hBF);
      wr(6'h2C, 8'h0E);
      check("bypass", {7'h0, csma_bypass}, 8'h01);
      $display("test results done");
      // Slower host for the random pass
      i_host.half = 5;
      for (int i = 0; i < 12; i++) begin
         v = rnd();
         v[4] = v[4] | v[5];
         wr(ra[i % 3], v);
         rd(ra[i % 3], v & rm[i % 3]);
         if (i % 3 == 0)
            check("fcs enable", {7'h0, auto_fcs_enable}, {7'h0, v[5]});
         if (i % 3 == 1)
            check("receive options",
               {ack_delay_symbols, 1'b0, reserved_type_filter,
               reserved_type_upload, promiscuous_enable},
               {v[2] ? 4'h2 : 4'hC, 1'b0, v[5], v[4], v[1]});
         if (i % 3 == 2)
            check("retry fields",
               {frame_retry_limit, channel_access_retry_limit,
               slotted_operation}, v);
      end
      i_host.half = 3;
      $display("test registers done");
      for (int i = 0; i < 5; i++) begin
         wr(6'h17, fx[i]);
         frame(fq[i]);
         check("frame pulses", {5'h0, frame_end_irq, address_match_irq,
            frame_discard}, {5'h0, fe[i]});
      end
      $display("test frames done");
      for (int i = 0; i < 4; i++) begin
         wr(6'h17, ax[i]);
         high_rate_group <= ah[i];
         ack_suppress <= as[i];
         frame(4'h7);
         v = launches;
         for (int t = 1; t <= an[i]; t++) begin
            if (t == an[i]) check("early ack", launches - v, 8'h00);
            repeat (2) @(posedge mclk);
            symbol_tick <= 1'b1;
            @(posedge mclk);
            symbol_tick <= 1'b0;
         end
         repeat (4) @(posedge mclk);
         #1;
         check("ack launch", launches - v, {7'h0, !as[i]});
      end
      $display("test acknowledgments done");
      tally_and_finish();
   end
endmodule

bind radio_extended_mode_control radio_xmode_properties i_props (.*);
